// ==== common/sadc_pkg.sv ====
// Shared constants and types of the SAR converter control block
package sadc_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int SADC_NCH = 10;
  localparam int SADC_RBITS = 10;
  localparam logic [3:0] SADC_LAST_CH = 4'h9;
  localparam logic [3:0] SADC_MSB_IDX = 4'h9;
  localparam logic [9:0] SADC_MSB_TRIAL = 10'h200;
  // ---------------------------------------------------------------
  // Register byte offsets and result page codes
  // ---------------------------------------------------------------
  localparam logic [7:0] SADC_OFS_MODE = 8'h00;
  localparam logic [7:0] SADC_OFS_TIME = 8'h04;
  localparam logic [7:0] SADC_OFS_HWT = 8'h08;
  localparam logic [7:0] SADC_OFS_CHAN = 8'h0C;
  localparam logic [7:0] SADC_OFS_PFM = 8'h10;
  localparam logic [7:0] SADC_OFS_PFT = 8'h14;
  localparam logic [7:0] SADC_OFS_STS = 8'h18;
  localparam logic [7:0] SADC_OFS_MSK = 8'h1C;
  localparam logic [1:0] SADC_RES_PAGE = 2'h1;
  localparam logic [1:0] SADC_RESH_PAGE = 2'h2;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SADC_B_EN = 7;
  localparam int SADC_B_MD = 4;
  localparam int SADC_B_ETS = 2;
  localparam int SADC_B_TMD = 1;
  localparam int SADC_B_BUSY = 0;
  localparam int SADC_B_PFEN = 7;
  localparam int SADC_B_PFGE = 6;
  localparam int SADC_B_TMR = 0;
  localparam int SADC_B_DONE = 0;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SADC_RST_MODE = 8'h00;
  localparam logic [7:0] SADC_RST_TIME = 8'h00;
  localparam logic [3:0] SADC_RST_CHAN = 4'h0;
  localparam logic [7:0] SADC_RST_PFT = 8'h00;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SADC_MD_SEL = 2'b00,
    SADC_MD_SCAN = 2'b01,
    SADC_MD_BAD = 2'b10,
    SADC_MD_ONE = 2'b11
  } sadc_mode_t;
  typedef enum logic [1:0] {
    SADC_ST_IDLE = 2'b00,
    SADC_ST_SAMP = 2'b01,
    SADC_ST_CONV = 2'b11,
    SADC_ST_DONE = 2'b10
  } sadc_state_t;
endpackage

// ==== hdl/sadc_ctrl.sv ====
// SAR converter control with AHB-Lite registers and power-fail compare
// Operation
// RULE1 - 10-bit value from one of ten channels
// RULE2 - Without compare, interrupt after every conversion
// RULE3 - With compare, interrupt only when condition holds
// RULE4 - Approximation resolves MSB first down to LSB
// RULE5 - After LSB, copy result to channel register
// RULE6 - Result word: upper ten bits, low six zero
// RULE7 - Per-channel byte view of upper eight bits
// RULE8 - Threshold is eight bits versus high byte
// RULE9 - Select, continuous scan and one-shot scan modes
// RULE10 - Start by software, external edge or timer
// RULE11 - Unselected analog pins stay usable as ports
// RULE12 - Separate mode, time, trigger, power-fail registers
// RULE13 - Enable bit gates conversion; busy flag read-only
// RULE14 - Mode codes 00,01,11; code 10 prohibited
// RULE15 - Edge codes none, falling, rising, both
// RULE16 - Config write while busy restarts or aborts (a time register write does neither)
// RULE17 - Compare enable and below or at-least select
// RULE18 - Scan ascends from channel zero to selected
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sadc_ctrl
  import sadc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cmp_in,
  input wire logic external_trigger_pin,
  input wire logic timer_trig,
  output logic [9:0] dac_code,
  output logic [3:0] mux_sel,
  output logic sample_hold,
  output logic [9:0] port_pin_en,
  output logic conversion_done_irq
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [1:0] mode;
    logic [1:0] edge_sel;
    logic tmd;
    logic [7:0] ctime;
    logic tmr_sel;
    logic [3:0] chsel;
    logic pf_en;
    logic pf_ge;
    logic [7:0] pf_thr;
    logic sts;
    logic msk;
    logic [9:0][9:0] res;
    sadc_state_t state;
    logic [3:0] ch_cur;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic [3:0] step_cnt;
    logic shot_done;
    logic cmp_s1;
    logic cmp_s2;
    logic trg_s1;
    logic trg_s2;
    logic trg_d;
    logic wr_pend;
    logic [5:0] wr_addr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    logic irq;
    logic samp;
    logic [9:0] pen;
  } sadc_regs_t;

  sadc_regs_t q;
  sadc_regs_t n;
  logic restart;
  logic ev_done;
  logic trig;
  logic clr;
  logic step_end;
  logic go_ok;
  logic last;
  logic pf_hit;
  logic [3:0] first_ch;
  logic [3:0] ridx;
  logic [7:0] wd;
  logic [7:0] hi;
  logic [7:0] raddr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = q;
    restart = 1'b0;
    ev_done = 1'b0;
    clr = 1'b0;
    wd = hwdata[7:0];
    raddr = haddr[7:0];
    ridx = haddr[5:2];
    hi = q.sar[9:2];
    step_end = (q.step_cnt == q.ctime[3:0]);
    go_ok = q.en & (q.mode != SADC_MD_BAD); // RULE13 RULE14
    first_ch = (q.mode == SADC_MD_SEL) ? q.chsel : 4'h0; // RULE18
    last = (q.mode == SADC_MD_SEL) | (q.ch_cur == q.chsel);
    // Compare uses only the high byte of the result
    pf_hit = q.pf_ge ? (hi >= q.pf_thr) : (hi < q.pf_thr); // RULE8 RULE17
    // Pins from outside pass two flops before any use
    n.cmp_s1 = cmp_in;
    n.cmp_s2 = q.cmp_s1;
    n.trg_s1 = external_trigger_pin;
    n.trg_s2 = q.trg_s1;
    n.trg_d = q.trg_s2;
    // Edge select on the synchronised pin, or the timer pulse
    trig = q.tmr_sel ? timer_trig :
      ((q.edge_sel[0] & ~q.trg_s2 & q.trg_d) |
       (q.edge_sel[1] & q.trg_s2 & ~q.trg_d)); // RULE10 RULE15

    // Address phase: reads answer at once, writes wait for data
    n.wr_pend = hsel & htrans[1] & hready & hwrite;
    n.wr_addr = haddr[7:2];
    n.rdata = 32'h0;
    if (hsel & htrans[1] & hready & ~hwrite)
    begin
      case (raddr)
        SADC_OFS_MODE: n.rdata = {24'h0, q.en, 1'b0, q.mode,
          q.edge_sel, q.tmd, q.state != SADC_ST_IDLE}; // RULE13
        SADC_OFS_TIME: n.rdata = {24'h0, q.ctime};
        SADC_OFS_HWT: n.rdata = {31'h0, q.tmr_sel};
        SADC_OFS_CHAN: n.rdata = {28'h0, q.chsel};
        SADC_OFS_PFM: n.rdata = {24'h0, q.pf_en, q.pf_ge, 6'h0};
        SADC_OFS_PFT: n.rdata = {24'h0, q.pf_thr};
        SADC_OFS_STS: n.rdata = {31'h0, q.sts};
        SADC_OFS_MSK: n.rdata = {31'h0, q.msk};
        default:
        begin
          // Result pages; indices past the last channel read zero
          if (raddr[1:0] == 2'b00 && ridx <= SADC_LAST_CH)
          begin
            if (raddr[7:6] == SADC_RES_PAGE)
              n.rdata = {16'h0, q.res[ridx], 6'h00}; // RULE6
            else if (raddr[7:6] == SADC_RESH_PAGE)
              n.rdata = {24'h0, q.res[ridx][9:2]}; // RULE7
          end
        end
      endcase
    end

    // Data phase: registers split by role
    if (q.wr_pend)
    begin
      case ({q.wr_addr, 2'b00})
        SADC_OFS_MODE:
        begin
          n.en = wd[SADC_B_EN];
          n.mode = wd[SADC_B_MD+:2];
          n.edge_sel = wd[SADC_B_ETS+:2];
          n.tmd = wd[SADC_B_TMD]; // busy bit ignores writes
          n.shot_done = 1'b0;
          restart = 1'b1; // RULE12
        end
        SADC_OFS_TIME: n.ctime = wd;
        SADC_OFS_HWT:
        begin
          n.tmr_sel = wd[SADC_B_TMR];
          restart = 1'b1;
        end
        SADC_OFS_CHAN:
        begin
          // Clamp so a scan never runs past the last channel
          n.chsel = (wd[3:0] > SADC_LAST_CH) ? SADC_LAST_CH : wd[3:0];
          restart = 1'b1; // RULE1
        end
        SADC_OFS_PFM:
        begin
          n.pf_en = wd[SADC_B_PFEN];
          n.pf_ge = wd[SADC_B_PFGE]; // RULE17
          restart = 1'b1;
        end
        SADC_OFS_PFT:
        begin
          n.pf_thr = wd;
          restart = 1'b1;
        end
        SADC_OFS_STS: clr = wd[SADC_B_DONE];
        SADC_OFS_MSK: n.msk = wd[SADC_B_DONE];
        default: ;
      endcase
    end

    // Sequencer: sample step, ten bit steps, store
    unique case (q.state)
      SADC_ST_IDLE:
      begin
        // Software mode runs on its own; hardware waits for trigger
        if (go_ok & (q.tmd ? trig : ~q.shot_done)) // RULE10
        begin
          n.state = SADC_ST_SAMP;
          n.ch_cur = first_ch;
          n.step_cnt = 4'h0;
        end
      end
      SADC_ST_SAMP:
      begin
        n.step_cnt = 4'(q.step_cnt + 4'h1);
        if (step_end)
        begin
          n.state = SADC_ST_CONV;
          n.bit_idx = SADC_MSB_IDX;
          n.sar = SADC_MSB_TRIAL; // RULE4
          n.step_cnt = 4'h0;
        end
      end
      SADC_ST_CONV:
      begin
        n.step_cnt = 4'(q.step_cnt + 4'h1);
        if (step_end)
        begin
          // Keep the trial bit only if input is at or above the DAC
          n.sar[q.bit_idx] = q.cmp_s2; // RULE4
          n.step_cnt = 4'h0;
          if (q.bit_idx == 4'h0)
            n.state = SADC_ST_DONE;
          else
          begin
            n.bit_idx = 4'(q.bit_idx - 4'h1);
            n.sar[4'(q.bit_idx - 4'h1)] = 1'b1;
          end
        end
      end
      SADC_ST_DONE:
      begin
        n.res[q.ch_cur] = q.sar; // RULE5
        ev_done = q.pf_en ? pf_hit : 1'b1; // RULE2 RULE3
        n.step_cnt = 4'h0;
        if (q.tmd & last)
          n.state = SADC_ST_IDLE;
        else if ((q.mode == SADC_MD_ONE) & last)
        begin
          n.state = SADC_ST_IDLE;
          n.shot_done = 1'b1; // RULE9
        end
        else
        begin
          n.state = SADC_ST_SAMP;
          // Select repeats; scans step up and wrap to zero
          n.ch_cur = (q.mode == SADC_MD_SEL) ? q.chsel :
            (last ? 4'h0 : 4'(q.ch_cur + 4'h1)); // RULE9 RULE18
        end
      end
    endcase

    // Disable halts at once; a write while busy to the mode, trigger, channel or power-fail registers aborts.
    // Software mode then restarts from idle one cycle later.
    if (~go_ok)
      n.state = SADC_ST_IDLE; // RULE13
    else if (restart & (q.state != SADC_ST_IDLE))
      n.state = SADC_ST_IDLE; // RULE16

    // Sticky done flag: a set in the clearing cycle wins
    n.sts = (q.sts & ~clr) | ev_done;
    n.irq = n.sts & n.msk;
    n.samp = (n.state == SADC_ST_SAMP);
    // Only the converting channel is taken from the port
    n.pen = '1;
    if (n.state != SADC_ST_IDLE)
      n.pen[n.ch_cur] = 1'b0; // RULE11

    if (sys_rst)
    begin
      n = '0;
      {n.en, n.mode, n.edge_sel, n.tmd} =
        {SADC_RST_MODE[7], SADC_RST_MODE[5:1]};
      n.ctime = SADC_RST_TIME;
      n.chsel = SADC_RST_CHAN;
      n.pf_thr = SADC_RST_PFT;
      n.rdy = 1'b1;
      n.pen = '1;
    end
  end

  // Single register for all state
  always_ff @(posedge sys_clk)
  begin
    q <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout = q.rdy;
  assign hresp = q.resp;
  assign hrdata = q.rdata;
  assign dac_code = q.sar;
  assign mux_sel = q.ch_cur;
  assign sample_hold = q.samp;
  assign port_pin_en = q.pen;
  assign conversion_done_irq = q.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  chk_msb_first: assert property ( // RULE4
    q.state == SADC_ST_SAMP && n.state == SADC_ST_CONV |=>
    q.sar == 10'h200 && q.bit_idx == 4'h9)
    else $error("approximation did not start at MSB");
  chk_result_store: assert property ( // RULE5
    q.state == SADC_ST_DONE |=> q.res[$past(q.ch_cur)] == $past(q.sar))
    else $error("result not stored in channel register");
  chk_irq_plain: assert property ( // RULE2
    q.state == SADC_ST_DONE && !q.pf_en && q.msk |=>
    conversion_done_irq ##1 q.state != SADC_ST_DONE)
    else $error("done interrupt missing");
  chk_pf_block: assert property ( // RULE3
    q.state == SADC_ST_DONE && q.pf_en && !pf_hit && !q.sts |=> !q.sts)
    else $error("interrupt raised with compare false");
  chk_busy_read: assert property ( // RULE13
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == SADC_OFS_MODE
    |=> hrdata[0] == ($past(q.state) != SADC_ST_IDLE))
    else $error("busy flag misreported");
  chk_disable_stop: assert property ( // RULE13
    !q.en && !n.en |=> q.state == SADC_ST_IDLE [*2])
    else $error("conversion runs while disabled");
  chk_bad_mode: assert property ( // RULE14
    q.mode == SADC_MD_BAD |=> q.state == SADC_ST_IDLE)
    else $error("prohibited mode converts");
  chk_restart: assert property ( // RULE16
    restart && q.state != SADC_ST_IDLE |=> q.state == SADC_ST_IDLE)
    else $error("config write did not abort");
  chk_scan_up: assert property ( // RULE18
    q.state == SADC_ST_DONE && n.state == SADC_ST_SAMP &&
    q.mode == SADC_MD_SCAN && !last |=>
    q.ch_cur == 4'($past(q.ch_cur) + 4'h1))
    else $error("scan order broken");
  chk_port_free: assert property ( // RULE11
    q.state != SADC_ST_IDLE |-> !port_pin_en[q.ch_cur] &&
    $countones(port_pin_en) == 9)
    else $error("port pins wrongly claimed");
  chk_low_zero: assert property ( // RULE6
    hsel && htrans[1] && hready && !hwrite &&
    haddr[7:6] == SADC_RES_PAGE |=> hrdata[5:0] == 6'h00)
    else $error("result low bits not zero");

  cov_oneshot: cover property (
    q.mode == SADC_MD_ONE && q.state == SADC_ST_DONE && last);
  cov_pf_fire: cover property (
    q.state == SADC_ST_DONE && q.pf_en && pf_hit);
  cov_hw_start: cover property (
    q.state == SADC_ST_IDLE && q.tmd && trig && go_ok);
  cov_restart: cover property (restart && q.state == SADC_ST_CONV);
endmodule // sadc_ctrl
`default_nettype wire

// ==== verif/sadc_analog_src.sv ====
// Analog source model: ten input levels seen through the comparator
`timescale 1ns/100ps
`default_nettype none
module sadc_analog_src
(
  input wire logic [9:0] dac_code,
  input wire logic [3:0] mux_sel,
  input wire logic [99:0] levels,
  output logic cmp_in
);
  // -------------------------------------------------------------
  // Comparator
  // -------------------------------------------------------------
  logic [9:0] lvl;
  // Channel codes above nine read as zero volts, not as the last level
  assign lvl = (mux_sel > 4'h9) ? 10'h000 : levels[mux_sel * 10 +: 10];
  // High when the held input is at or above the trial level
  assign cmp_in = (lvl >= dac_code);
endmodule // sadc_analog_src
`default_nettype wire

// ==== verif/test_sar_adc_control_power_fail.sv ====
// Self-checking bench of the SAR converter control block
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_control_power_fail
  import sadc_pkg::*;
;
  logic sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic ext = 1'b0, tmr = 1'b0, dph = 1'b0, cmp, hreadyout, hresp, irq, sh;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv, e;
  logic [9:0] dac, ppe, lv0;
  logic [3:0] mux, chv;
  logic [99:0] lv = 100'h0;
  logic [7:0] hb;
  logic [1:0] ev;
  logic [31:0] exp_q[$];
  int error_cnt = 0, checks = 0, i, k;
  always #10 sys_clk = ~sys_clk;
  sadc_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmp_in(cmp),
    .external_trigger_pin(ext), .timer_trig(tmr), .dac_code(dac),
    .mux_sel(mux), .sample_hold(sh), .port_pin_en(ppe),
    .conversion_done_irq(irq));
  sadc_analog_src src (.dac_code(dac), .mux_sel(mux), .levels(lv),
    .cmp_in(cmp));
  // -------------------------------------------------------------
  // Checking
  // -------------------------------------------------------------
  task print_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Read data is judged at the edge that ends its data phase
  always @(posedge sys_clk)
  begin
    if (dph === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      checks++;
      if (hrdata !== e)
      begin
        error_cnt++;
        $display("[ERR] %0t read %h expected %h", $time, hrdata, e);
      end
    end
  end
  // -------------------------------------------------------------
  // Bus tasks
  // -------------------------------------------------------------
  // One single transfer; c queues d as the expected read data
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic c);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    dph <= c;
    if (c) exp_q.push_back(d);
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rdv = hrdata;
    dph <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b0, a, d, 1'b1);
  endtask
  // Bounded wait for the interrupt; a miss counts as a mismatch
  task wirq;
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge sys_clk);
    chk(irq === 1'b1, "interrupt missing");
  endtask
  task wait_chk(input int n, input logic v);
    repeat (n) @(posedge sys_clk);
    #1 chk(irq === v, "interrupt level wrong");
    // Back onto the edge so the next stimulus lands on it
    @(posedge sys_clk);
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h0c9fbfa9));
    for (i = 0; i < 10; i++) lv[i * 10 +: 10] = 10'($urandom);
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h00, 32'h0);
    rd(8'h3C, 32'h0);
    chk(ppe === 10'h3FF && irq === 1'b0, "reset outputs");
    chk(hresp === 1'b0 && dac === 10'h000, "reset bus or dac");
    hb = 8'($urandom);
    wr(8'h14, {24'h0, hb});
    rd(8'h14, {24'h0, hb});
    wr(8'h0C, 32'hF);
    rd(8'h0C, 32'h9);
    wr(8'h00, 32'h31);
    rd(8'h00, 32'h30);
    wr(8'h04, 32'h2);
    wr(8'h1C, 32'h1);
    // Software start, select mode on a random channel
    chv = 4'($urandom_range(0, 9));
    lv0 = lv[chv * 10 +: 10];
    wr(8'h0C, {28'h0, chv});
    wr(8'h00, 32'h80);
    repeat (3) @(posedge sys_clk);
    chk(mux === chv && ppe === ~(10'h001 << chv), "pin use");
    chk(sh === 1'b1, "sample step not shown");
    wirq();
    wr(8'h00, 32'h0);
    rd(8'h40 + {2'h0, chv, 2'h0}, {16'h0, lv0, 6'h0});
    rd(8'h80 + {2'h0, chv, 2'h0}, {24'h0, lv0[9:2]});
    rd(8'h18, 32'h1);
    wr(8'h1C, 32'h0);
    wait_chk(1, 1'b0);
    wr(8'h1C, 32'h1);
    wait_chk(1, 1'b1);
    wr(8'h18, 32'h1);
    wait_chk(1, 1'b0);
    // Prohibited mode code keeps the sequencer idle
    wr(8'h00, 32'hA0);
    wait_chk(30, 1'b0);
    rd(8'h00, 32'hA0);
    // One-shot pass over channels zero to three
    wr(8'h0C, 32'h3);
    wr(8'h00, 32'hB0);
    repeat (3) @(posedge sys_clk);
    for (k = 0; k < 1000; k++)
    begin
      xfer(1'b0, 8'h00, 32'h0, 1'b0);
      if (rdv[0] !== 1'b1) break;
    end
    for (i = 0; i < 4; i++)
      rd(8'h40 + 8'(i * 4), {16'h0, lv[i * 10 +: 10], 6'h0});
    // Continuous scan must wrap back to channel zero
    lv[19:0] = {10'($urandom), 10'($urandom)};
    wr(8'h0C, 32'h1);
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h90);
    repeat (3)
    begin
      wirq();
      wr(8'h18, 32'h1);
    end
    wr(8'h00, 32'h0);
    rd(8'h40, {16'h0, lv[9:0], 6'h0});
    rd(8'h44, {16'h0, lv[19:10], 6'h0});
    // Power-fail compare, threshold equal to the high byte
    wr(8'h0C, 32'h0);
    wr(8'h14, {24'h0, lv[9:2]});
    wr(8'h10, 32'h80);
    wr(8'h00, 32'hB0);
    wait_chk(80, 1'b0);
    wr(8'h10, 32'hC0);
    wr(8'h00, 32'hB0);
    wirq();
    wr(8'h18, 32'h1);
    // Timer trigger, then an abort by a write while busy
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h82);
    wait_chk(20, 1'b0);
    tmr <= 1'b1;
    @(posedge sys_clk);
    tmr <= 1'b0;
    wirq();
    wr(8'h18, 32'h1);
    tmr <= 1'b1;
    @(posedge sys_clk);
    tmr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(8'h14, 32'h0);
    wait_chk(60, 1'b0);
    // External pin, every edge code on both edges
    wr(8'h08, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      ev = i[1:0];
      wr(8'h00, 32'h82 | {28'h0, ev, 2'h0});
      wr(8'h18, 32'h1);
      ext <= 1'b1;
      wait_chk(60, ev[1]);
      wr(8'h18, 32'h1);
      ext <= 1'b0;
      wait_chk(60, ev[0]);
    end
    print_verdict();
  end
  // Cuts a hung run short at several times the expected length
  initial
  begin
    #400000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_sar_adc_control_power_fail
`default_nettype wire
